/* File: design/fsw_status_map.vh */
// constants of the flash status register and write enable latch block
// assumes a 100 MHz system clock and serial pins sampled by that clock
`ifndef FSW_STATUS_MAP_VH
`define FSW_STATUS_MAP_VH

// status register fields
`define FSW_ST_BUSY 0
`define FSW_ST_WEL 1
`define FSW_ST_BP_LO 2
`define FSW_ST_BP_HI 5
`define FSW_ST_QE 6
`define FSW_ST_LOCK 7
`define FSW_ST_RESET 8'h00
`define FSW_NV_RESET 6'h00

// status write cycle time
`define FSW_CLK_PERIOD_NS 10
`define FSW_STATUS_WRITE_CMD_TIME_NS 10000
// 10000 ns at 10 ns a cycle, sized to the 12-bit cycle timer
`define FSW_STATUS_WRITE_CMD_CYCLES 12'h3E8

// block geometry: 1024 blocks of 64KB
`define FSW_BLK_LSB 16
`define FSW_BLK_MSB 25
`define FSW_BLK_TOTAL 11'h400

// opcodes
`define FSW_OP_RDSR 8'h05
`define FSW_OP_WRITE_ENABLE_CMD 8'h06
`define FSW_OP_WRITE_DISABLE_CMD 8'h04
`define FSW_OP_STATUS_WRITE_CMD 8'h01
`define FSW_OP_RST_EN 8'h66
`define FSW_OP_RST 8'h99
`define FSW_OP_SUSP_A 8'h75
`define FSW_OP_SUSP_B 8'hB0
`define FSW_OP_PP 8'h02
`define FSW_OP_PP4 8'h12
`define FSW_OP_PPQ 8'h32
`define FSW_OP_PPQ4 8'h34
`define FSW_OP_PPQIO 8'h38
`define FSW_OP_PPQIO4 8'h3E
`define FSW_OP_SER_A 8'hD7
`define FSW_OP_SER_B 8'h20
`define FSW_OP_SER4 8'h21
`define FSW_OP_BE32 8'h52
`define FSW_OP_BE32_4 8'h5C
`define FSW_OP_BE64 8'hD8
`define FSW_OP_BE64_4 8'hDC
`define FSW_OP_CE_A 8'hC7
`define FSW_OP_CE_B 8'h60
`define FSW_OP_WRFR 8'h42
`define FSW_OP_RPNV 8'h65
`define FSW_OP_RPV 8'h63
`define FSW_OP_ERPNV 8'h85
`define FSW_OP_ERPV 8'h83
`define FSW_OP_IRER 8'h64
`define FSW_OP_IRP 8'h62
`define FSW_OP_BANKNV 8'h18
`define FSW_OP_BANKV 8'hC5
`define FSW_OP_DYB4 8'hFB
`define FSW_OP_DYB 8'hE1
`define FSW_OP_PPB 8'hFD
`define FSW_OP_PPB4 8'hE3
`define FSW_OP_ERPPB 8'hE4
`define FSW_OP_PGASP 8'h2F
`define FSW_OP_WRPLB 8'hA6
`define FSW_OP_FRZ 8'h91
`define FSW_OP_GLOCK 8'h7E
`define FSW_OP_GUNLOCK 8'h98
`define FSW_OP_PGPWD 8'hE8
`define FSW_OP_DLPNV 8'h43
`define FSW_OP_DLPV 8'h4A
`define FSW_OP_RPV_ALT 8'hC0
`define FSW_OP_BANKV_ALT 8'h17

`endif

/* File: design/fsw_nv_store.v */
// non-volatile status cells: lock, quad enable and four protect bits
// assumes writes arrive as one-cycle strobes from the status logic
`timescale 1ns/100ps
`include "fsw_status_map.vh"
module fsw_nv_store (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire wr_i,
  input wire [5:0] wdata_i,
  output reg [5:0] rdata_o
);
  reg [5:0] cells;

  // reset stands for the factory default of the cells
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cells <= `FSW_NV_RESET;
      rdata_o <= `FSW_NV_RESET;
    end else if (ce_i) begin
      if (wr_i) begin
        cells <= wdata_i;
      end
      rdata_o <= cells;
    end
  end
endmodule // fsw_nv_store

/* File: design/fsw_status_we.v */
// status register, write enable latch and write gating of a serial flash
// assumes serial pins synchronous to clk_i, sck at most a quarter of clk_i,
// and an array engine outside that runs the operations it is handed
`timescale 1ns/100ps
`include "fsw_status_map.vh"
module fsw_status_we (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  input wire wp_n_i,
  input wire top_bottom_select_i,
  input wire op_done_i,
  output reg so_o,
  output reg so_oe_o,
  output reg [7:0] device_status_o,
  output reg quad_pins_o,
  output reg wp_hold_pins_o,
  output reg op_req_o,
  output reg [7:0] op_code_o,
  output reg [31:0] op_addr_o,
  output reg op_suspend_o,
  output reg op_abort_o,
  output reg [7:0] prog_data_o,
  output reg prog_data_vld_o
);
  localparam ST_OPC = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_DATA = 3'd2;
  localparam ST_SRD = 3'd3;
  localparam ST_SKIP = 3'd4;

  reg [2:0] state;
  reg sck_q;
  reg cs_q;
  reg [2:0] bit_cnt;
  reg [6:0] shreg;
  reg [2:0] byte_cnt;
  reg [7:0] opcode;
  reg [31:0] addr;
  reg [7:0] wr_data;
  reg have_data;
  reg [7:0] out_sh;
  reg [2:0] out_cnt;
  reg write_enable_latch;
  reg write_in_progress;
  reg eng_busy;
  reg eng_pe;
  reg rst_arm;
  reg [11:0] status_write_cmd_tmr;
  reg nv_wr;
  reg [5:0] nv_wdata;
  wire [5:0] nv_rdata;

  wire [7:0] rx_byte;
  wire sck_rise;
  wire sck_fall;
  wire cs_rise;
  wire [3:0] block_protect;
  wire quad_enable;
  wire status_write_lock;
  wire [7:0] status_now;
  wire area_hit;

  // opcodes that must follow a write enable
  function needs_wel;
    input [7:0] op;
    begin
      case (op)
        `FSW_OP_PP, `FSW_OP_PP4, `FSW_OP_PPQ, `FSW_OP_PPQ4,
        `FSW_OP_PPQIO, `FSW_OP_PPQIO4: needs_wel = 1'b1;
        `FSW_OP_SER_A, `FSW_OP_SER_B, `FSW_OP_SER4, `FSW_OP_BE32,
        `FSW_OP_BE32_4, `FSW_OP_BE64, `FSW_OP_BE64_4, `FSW_OP_CE_A,
        `FSW_OP_CE_B: needs_wel = 1'b1;
        `FSW_OP_STATUS_WRITE_CMD, `FSW_OP_WRFR, `FSW_OP_RPNV, `FSW_OP_RPV,
        `FSW_OP_ERPNV, `FSW_OP_ERPV, `FSW_OP_IRER, `FSW_OP_IRP,
        `FSW_OP_BANKNV, `FSW_OP_BANKV: needs_wel = 1'b1;
        `FSW_OP_DYB4, `FSW_OP_DYB, `FSW_OP_PPB, `FSW_OP_PPB4,
        `FSW_OP_ERPPB, `FSW_OP_PGASP, `FSW_OP_WRPLB, `FSW_OP_FRZ,
        `FSW_OP_GLOCK, `FSW_OP_GUNLOCK, `FSW_OP_PGPWD, `FSW_OP_DLPNV,
        `FSW_OP_DLPV: needs_wel = 1'b1;
        default: needs_wel = 1'b0;
      endcase
    end
  endfunction

  // number of address bytes that follow the opcode
  function [2:0] addr_len;
    input [7:0] op;
    begin
      case (op)
        `FSW_OP_PP4, `FSW_OP_PPQ4, `FSW_OP_PPQIO4, `FSW_OP_SER4,
        `FSW_OP_BE32_4, `FSW_OP_BE64_4, `FSW_OP_DYB4,
        `FSW_OP_PPB4: addr_len = 3'd4;
        `FSW_OP_PP, `FSW_OP_PPQ, `FSW_OP_PPQIO, `FSW_OP_SER_A,
        `FSW_OP_SER_B, `FSW_OP_BE32, `FSW_OP_BE64, `FSW_OP_DYB,
        `FSW_OP_PPB: addr_len = 3'd3;
        default: addr_len = 3'd0;
      endcase
    end
  endfunction

  // program or erase that targets an address
  function is_pe;
    input [7:0] op;
    begin
      case (op)
        `FSW_OP_PP, `FSW_OP_PP4, `FSW_OP_PPQ, `FSW_OP_PPQ4,
        `FSW_OP_PPQIO, `FSW_OP_PPQIO4, `FSW_OP_SER_A, `FSW_OP_SER_B,
        `FSW_OP_SER4, `FSW_OP_BE32, `FSW_OP_BE32_4, `FSW_OP_BE64,
        `FSW_OP_BE64_4: is_pe = 1'b1;
        default: is_pe = 1'b0;
      endcase
    end
  endfunction

  function is_prog;
    input [7:0] op;
    begin
      case (op)
        `FSW_OP_PP, `FSW_OP_PP4, `FSW_OP_PPQ, `FSW_OP_PPQ4,
        `FSW_OP_PPQIO, `FSW_OP_PPQIO4: is_prog = 1'b1;
        default: is_prog = 1'b0;
      endcase
    end
  endfunction

  // commands still heard while an operation runs
  function busy_ok;
    input [7:0] op;
    begin
      case (op)
        `FSW_OP_RDSR, `FSW_OP_RST_EN, `FSW_OP_RST, `FSW_OP_SUSP_A,
        `FSW_OP_SUSP_B: busy_ok = 1'b1;
        default: busy_ok = 1'b0;
      endcase
    end
  endfunction

  // protected area test for one 64KB block
  function prot_hit;
    input [3:0] bp;
    input top_bottom_select;
    input [9:0] blk;
    reg [10:0] cnt;
    begin
      cnt = 11'h000;
      case (bp)
        4'hA: cnt = 11'h200;
        4'hB: cnt = 11'h300;
        4'hC: cnt = 11'h380;
        4'hD: cnt = 11'h3C0;
        4'hE: cnt = 11'h3E0;
        4'hF: cnt = `FSW_BLK_TOTAL;
        4'h0: cnt = 11'h000;
        default: cnt = 11'h001 << (bp - 4'h1);
      endcase
      if (top_bottom_select) begin
        prot_hit = ({1'b0, blk} < cnt);
      end else begin
        prot_hit = ({1'b0, blk} >= (`FSW_BLK_TOTAL - cnt));
      end
    end
  endfunction

  assign rx_byte = {shreg, si_i};
  assign sck_rise = sck_i & ~sck_q & ~cs_n_i;
  assign sck_fall = ~sck_i & sck_q & ~cs_n_i;
  assign cs_rise = cs_n_i & ~cs_q;
  assign block_protect = nv_rdata[3:0];
  assign quad_enable = nv_rdata[4];
  assign status_write_lock = nv_rdata[5];
  assign status_now = {nv_rdata, write_enable_latch,
    write_in_progress};
  assign area_hit = prot_hit(block_protect, top_bottom_select_i,
    addr[`FSW_BLK_MSB:`FSW_BLK_LSB]);

  fsw_nv_store u_nv (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .wr_i(nv_wr),
    .wdata_i(nv_wdata),
    .rdata_o(nv_rdata)
  );

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_OPC;
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      bit_cnt <= 3'd0;
      shreg <= 7'h00;
      byte_cnt <= 3'd0;
      opcode <= 8'h00;
      addr <= 32'h00000000;
      wr_data <= 8'h00;
      have_data <= 1'b0;
      out_sh <= 8'h00;
      out_cnt <= 3'd0;
      write_enable_latch <= 1'b0;
      write_in_progress <= 1'b0;
      eng_busy <= 1'b0;
      eng_pe <= 1'b0;
      rst_arm <= 1'b0;
      status_write_cmd_tmr <= 12'h000;
      nv_wr <= 1'b0;
      nv_wdata <= 6'h00;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
      device_status_o <= `FSW_ST_RESET;
      quad_pins_o <= 1'b0;
      wp_hold_pins_o <= 1'b1;
      op_req_o <= 1'b0;
      op_code_o <= 8'h00;
      op_addr_o <= 32'h00000000;
      op_suspend_o <= 1'b0;
      op_abort_o <= 1'b0;
      prog_data_o <= 8'h00;
      prog_data_vld_o <= 1'b0;
    end else if (ce_i) begin
      sck_q <= sck_i;
      cs_q <= cs_n_i;
      op_req_o <= 1'b0;
      op_suspend_o <= 1'b0;
      op_abort_o <= 1'b0;
      prog_data_vld_o <= 1'b0;
      nv_wr <= 1'b0;
      device_status_o <= status_now;
      quad_pins_o <= quad_enable;
      wp_hold_pins_o <= ~quad_enable;
      // status write cycle timing
      if (status_write_cmd_tmr != 12'h000) begin
        status_write_cmd_tmr <= status_write_cmd_tmr - 12'h001;
        if (status_write_cmd_tmr == 12'h001) begin
          write_in_progress <= 1'b0;
          write_enable_latch <= 1'b0;
        end
      end
      // engine finished, passed or failed alike
      if (op_done_i && eng_busy) begin
        eng_busy <= 1'b0;
        eng_pe <= 1'b0;
        write_in_progress <= 1'b0;
        write_enable_latch <= 1'b0;
      end
      if (cs_n_i) begin
        state <= ST_OPC;
        bit_cnt <= 3'd0;
        so_oe_o <= 1'b0;
        have_data <= 1'b0;
      end else if (sck_rise) begin
        shreg <= rx_byte[6:0];
        bit_cnt <= bit_cnt + 3'd1;
        if (bit_cnt == 3'd7) begin
          case (state)
            ST_OPC: begin
              opcode <= rx_byte;
              byte_cnt <= 3'd0;
              addr <= 32'h00000000;
              if (write_in_progress && !busy_ok(rx_byte)) begin
                state <= ST_SKIP;
              end else if (rx_byte == `FSW_OP_RDSR) begin
                state <= ST_SRD;
                out_sh <= status_now;
                out_cnt <= 3'd0;
              end else if (addr_len(rx_byte) != 3'd0) begin
                state <= ST_ADDR;
              end else begin
                state <= ST_DATA;
              end
            end
            ST_ADDR: begin
              addr <= {addr[23:0], rx_byte};
              byte_cnt <= byte_cnt + 3'd1;
              if (byte_cnt == addr_len(opcode) - 3'd1) begin
                state <= ST_DATA;
              end
            end
            ST_DATA: begin
              if (!have_data) begin
                wr_data <= rx_byte;
                have_data <= 1'b1;
              end
              // data only flows into a program that may run
              if (is_prog(opcode) && write_enable_latch && !area_hit) begin
                prog_data_o <= rx_byte;
                prog_data_vld_o <= 1'b1;
              end
            end
            default: begin
              state <= state;
            end
          endcase
        end
      end else if (sck_fall && state == ST_SRD) begin
        so_oe_o <= 1'b1;
        so_o <= out_sh[7];
        out_cnt <= out_cnt + 3'd1;
        // reload after each byte so the register streams again
        if (out_cnt == 3'd7) begin
          out_sh <= status_now;
        end else begin
          out_sh <= {out_sh[6:0], 1'b0};
        end
      end
      // commands act on select rising after whole bytes only
      if (cs_rise && bit_cnt == 3'd0 && state == ST_DATA) begin
        rst_arm <= (opcode == `FSW_OP_RST_EN);
        if (opcode == `FSW_OP_WRITE_ENABLE_CMD) begin
          write_enable_latch <= 1'b1;
        end else if (opcode == `FSW_OP_WRITE_DISABLE_CMD) begin
          write_enable_latch <= 1'b0;
        end else if (opcode == `FSW_OP_RST) begin
          if (rst_arm) begin
            write_enable_latch <= 1'b0;
            write_in_progress <= 1'b0;
            eng_busy <= 1'b0;
            eng_pe <= 1'b0;
            status_write_cmd_tmr <= 12'h000;
            op_abort_o <= 1'b1;
          end
        end else if (opcode == `FSW_OP_RST_EN) begin
          // arming must survive a busy period, reset is heard while busy
          rst_arm <= 1'b1;
        end else if (opcode == `FSW_OP_SUSP_A ||
            opcode == `FSW_OP_SUSP_B) begin
          if (eng_busy && eng_pe) begin
            op_suspend_o <= 1'b1;
          end
        end else if (write_in_progress) begin
          rst_arm <= 1'b0;
        end else if (needs_wel(opcode) && !write_enable_latch) begin
          rst_arm <= 1'b0;
        end else if (opcode == `FSW_OP_STATUS_WRITE_CMD) begin
          // the latch is left as is here; it clears when the cycle ends
          if (have_data && !(status_write_lock && !wp_n_i)) begin
            nv_wr <= 1'b1;
            nv_wdata <= wr_data[`FSW_ST_LOCK:`FSW_ST_BP_LO];
            write_in_progress <= 1'b1;
            status_write_cmd_tmr <= `FSW_STATUS_WRITE_CMD_CYCLES;
          end
        end else if (opcode == `FSW_OP_CE_A || opcode == `FSW_OP_CE_B) begin
          if (block_protect == 4'h0) begin
            op_req_o <= 1'b1;
            op_code_o <= opcode;
            op_addr_o <= 32'h00000000;
            write_in_progress <= 1'b1;
            eng_busy <= 1'b1;
            eng_pe <= 1'b1;
          end
        end else if (is_pe(opcode)) begin
          if (!area_hit) begin
            op_req_o <= 1'b1;
            op_code_o <= opcode;
            op_addr_o <= addr;
            write_in_progress <= 1'b1;
            eng_busy <= 1'b1;
            eng_pe <= 1'b1;
          end
        end else if (needs_wel(opcode)) begin
          op_req_o <= 1'b1;
          op_code_o <= opcode;
          op_addr_o <= addr;
          write_in_progress <= 1'b1;
          eng_busy <= 1'b1;
        end else if (opcode == `FSW_OP_RPV_ALT ||
            opcode == `FSW_OP_BANKV_ALT) begin
          // volatile writes: handed over, no busy period
          op_req_o <= 1'b1;
          op_code_o <= opcode;
          op_addr_o <= {24'h000000, wr_data};
        end
      end
    end
  end
endmodule // fsw_status_we

/* File: testbench/fsw_host_model.sv */
// host side of the serial link: select, serial clock and data, mode 0
// assumes the device samples these pins with clk_i, so levels last HALF
`timescale 1ns/100ps
module fsw_host_model #(
  parameter int HALF = 4
) (
  input wire clk_i,
  input wire so_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end

  // entered just after a clock edge; data moves while the clock is low
  task automatic shift(input logic b, output logic got);
    si_o <= b;
    repeat (HALF) @(posedge clk_i);
    got = so_i;
    sck_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
    sck_o <= 1'b0;
  endtask

  // n bytes from the top of d, msb first, then r bits read back
  task automatic frame(input int n, input logic [39:0] d, input int r,
                       output logic [15:0] rd);
    logic g;
    g = 1'b0;
    rd = 16'h0000;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
    for (int i = 0; i < 8 * n; i++)
      shift(d[39 - i], g);
    for (int i = 0; i < r; i++) begin
      // toggling input so a stale level is never mistaken for data
      shift(~g, g);
      rd = {rd[14:0], g};
    end
    repeat (HALF) @(posedge clk_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    repeat (HALF) @(posedge clk_i);
  endtask
endmodule // fsw_host_model

/* File: testbench/fsw_status_we_properties.sv */
// timing checks on the status and write enable block
// assumes it is bound to the ports of fsw_status_we
`timescale 1ns/100ps
module fsw_status_we_properties (
  input wire clk_i,
  input wire rst_n_i,
  input wire op_done_i,
  input wire [7:0] device_status_o,
  input wire quad_pins_o,
  input wire wp_hold_pins_o,
  input wire op_req_o,
  input wire [7:0] op_code_o,
  input wire so_oe_o
);
  wire alt_op;
  assign alt_op = (op_code_o == 8'hC0) || (op_code_o == 8'h17);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reset_all_zero: assert property (
    $rose(rst_n_i) |-> device_status_o == 8'h00)
    else $error("status not zero after reset");
  a_req_sets_busy: assert property (
    op_req_o && !alt_op |=> device_status_o[0])
    else $error("engine request without busy");
  a_alt_stays_idle: assert property (
    op_req_o && alt_op |=> !device_status_o[0])
    else $error("volatile alternate write went busy");
  a_req_needs_latch: assert property (
    op_req_o && !alt_op |-> device_status_o[1])
    else $error("write request with latch clear");
  a_busy_rise_latch: assert property (
    $rose(device_status_o[0]) |-> device_status_o[1])
    else $error("busy began without the latch");
  a_done_clears_both: assert property (
    op_done_i && device_status_o[0] |-> ##2 device_status_o[1:0] == 2'b00)
    else $error("busy or latch left after completion");
  a_busy_holds_on: assert property (
    $rose(device_status_o[0]) |-> device_status_o[0] [*6])
    else $error("busy dropped early");
  a_cells_need_busy: assert property (
    $changed(device_status_o[7:2]) |-> $past(device_status_o[0]))
    else $error("status cells moved outside a write");
  a_latch_rise_idle: assert property (
    $rose(device_status_o[1]) |-> !$past(device_status_o[0]))
    else $error("latch set while busy");
  a_pins_exclusive: assert property (
    quad_pins_o != wp_hold_pins_o)
    else $error("pin functions not exclusive");
  a_quad_tracks: assert property (
    $changed(device_status_o[6]) |-> ##[0:2] quad_pins_o == device_status_o[6])
    else $error("quad pins not following status");

  c_engine_req: cover property (op_req_o);
  c_busy_rise: cover property ($rose(device_status_o[0]));
  c_status_read: cover property (so_oe_o);
  c_quad_on: cover property (quad_pins_o);
endmodule // fsw_status_we_properties

/* File: testbench/fsw_status_we_tb.sv */
// self-checking bench for the status and write enable block
// assumes the host model drives the serial pins and the bench the engine
`timescale 1ns/100ps
module fsw_status_we_tb;
  localparam logic [7:0] WOPS [38] = '{8'h01, 8'h02, 8'h12, 8'h32, 8'h34,
    8'h38, 8'h3E, 8'hD7, 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC, 8'hC7,
    8'h60, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83, 8'h64, 8'h62, 8'h18, 8'hC5,
    8'hFB, 8'hE1, 8'hFD, 8'hE3, 8'hE4, 8'h2F, 8'hA6, 8'h91, 8'h7E, 8'h98,
    8'hE8, 8'h43, 8'h4A};
  localparam logic [39:0] WRITE_ENABLE_CMD = {8'h06, 32'h0};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wp_n_i = 1'b1;
  logic top_bottom_select = 1'b0;
  logic op_done_i = 1'b0;
  wire cs_n, sck, si, so_o, so_oe_o, quad_pins_o, wp_hold_pins_o, so_line;
  wire op_req_o, op_suspend_o, op_abort_o, prog_data_vld_o;
  wire [7:0] device_status_o, op_code_o, prog_data_o;
  wire [31:0] op_addr_o;
  int miscompares = 0;
  int samples_checked = 0;
  int req_cnt = 0;
  int susp_cnt = 0;
  int abort_cnt = 0;
  int vld_cnt = 0;

  always #5 clk_i = ~clk_i;
  // pulses are counted so a task can judge them after its frame ends
  always @(posedge clk_i) begin
    if (op_req_o === 1'b1) req_cnt <= req_cnt + 1;
    if (op_suspend_o === 1'b1) susp_cnt <= susp_cnt + 1;
    if (op_abort_o === 1'b1) abort_cnt <= abort_cnt + 1;
    if (prog_data_vld_o === 1'b1) vld_cnt <= vld_cnt + 1;
  end
  // released line shows a moving pattern, never the last driven bit
  assign so_line = (so_oe_o === 1'b1) ? so_o : clk_i;

  fsw_status_we dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .wp_n_i(wp_n_i),
    .top_bottom_select_i(top_bottom_select), .op_done_i(op_done_i), .so_o(so_o),
    .so_oe_o(so_oe_o), .device_status_o(device_status_o),
    .quad_pins_o(quad_pins_o), .wp_hold_pins_o(wp_hold_pins_o),
    .op_req_o(op_req_o), .op_code_o(op_code_o), .op_addr_o(op_addr_o),
    .op_suspend_o(op_suspend_o), .op_abort_o(op_abort_o),
    .prog_data_o(prog_data_o), .prog_data_vld_o(prog_data_vld_o));
  fsw_host_model host (.clk_i(clk_i), .so_i(so_line), .cs_n_o(cs_n),
    .sck_o(sck), .si_o(si));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic send(input int n, input logic [39:0] d);
    logic [15:0] x;
    host.frame(n, d, 0, x);
  endtask

  task automatic wait_ready(input int lim);
    int i;
    for (i = 0; i < lim && device_status_o[0] !== 1'b0; i++)
      @(posedge clk_i);
    if (i == lim) begin
      miscompares++;
      $display("[FAIL] %0t busy never cleared", $time);
      give_verdict();
    end
    repeat (2) @(posedge clk_i);
  endtask

  // engine answers late so busy is seen to stand for a while
  task automatic end_op();
    repeat (8) @(posedge clk_i);
    op_done_i <= 1'b1;
    @(posedge clk_i);
    op_done_i <= 1'b0;
    wait_ready(8);
  endtask

  task automatic wsr(input logic [7:0] d);
    send(1, WRITE_ENABLE_CMD);
    send(2, {8'h01, d, 24'h0});
    check(device_status_o[0], 1'b1);
    wait_ready(1100);
  endtask

  task automatic t_latch();
    check(device_status_o, 8'h00);
    check({quad_pins_o, wp_hold_pins_o}, 2'b01);
    send(1, WRITE_ENABLE_CMD);
    check(device_status_o, 8'h02);
    send(1, {8'h04, 32'h0});
    check(device_status_o, 8'h00);
  endtask

  task automatic t_no_latch();
    int r;
    r = req_cnt;
    foreach (WOPS[k]) begin
      send(5, {WOPS[k], 32'h0});
      check(device_status_o, 8'h00);
    end
    check(req_cnt, r);
    foreach (WOPS[k]) if (k < 2) begin
      send(2, {k ? 8'h17 : 8'hC0, 8'h5A, 24'h0});
      check(req_cnt, r + k + 1);
      check({op_code_o, op_addr_o[7:0]}, {k ? 8'h17 : 8'hC0, 8'h5A});
      check(device_status_o, 8'h00);
    end
  endtask

  task automatic t_engine();
    int r;
    for (int k = 1; k < 38; k++) begin
      r = req_cnt;
      send(1, WRITE_ENABLE_CMD);
      send(5, {WOPS[k], 32'h0});
      check({req_cnt[7:0], op_code_o}, {r[7:0] + 8'h01, WOPS[k]});
      check(device_status_o[1:0], 2'b11);
      if (k == 1) begin
        send(1, WRITE_ENABLE_CMD);
        send(1, {8'h04, 32'h0});
        check(device_status_o[1:0], 2'b11);
      end
      end_op();
      check(device_status_o[1:0], 2'b00);
    end
  endtask

  task automatic t_status();
    logic [15:0] rd;
    send(1, WRITE_ENABLE_CMD);
    send(2, {8'h01, 8'h7C, 24'h0});
    check(device_status_o[0], 1'b1);
    host.frame(1, {8'h05, 32'h0}, 16, rd);
    check(rd[15:8], 8'h7F);
    check(rd[7:0], 8'h7F);
    check(so_oe_o, 1'b0);
    wait_ready(1100);
    check(device_status_o, 8'h7C);
    check({quad_pins_o, wp_hold_pins_o}, 2'b10);
  endtask

  task automatic t_protect();
    int r;
    r = req_cnt;
    send(1, WRITE_ENABLE_CMD);
    send(5, {8'hC7, 32'h0});
    check(req_cnt, r);
    send(5, {8'h02, 24'h0, 8'h55});
    check(req_cnt, r);
    wsr(8'h04);
    for (int t = 0; t < 2; t++) begin
      top_bottom_select <= t[0];
      send(1, WRITE_ENABLE_CMD);
      send(5, {8'h12, t ? 32'h0 : 32'h03FF0000});
      check(req_cnt, r);
      send(5, {8'hC7, 32'h0});
      check(req_cnt, r);
      send(5, {8'h12, t ? 32'h03FF0000 : 32'h0});
      check(req_cnt, r + 1);
      end_op();
      r = req_cnt;
    end
  endtask

  task automatic t_lock();
    wsr(8'h80);
    check(device_status_o, 8'h80);
    wp_n_i <= 1'b0;
    send(1, WRITE_ENABLE_CMD);
    send(2, {8'h01, 8'h00, 24'h0});
    check(device_status_o, 8'h82);
    wp_n_i <= 1'b1;
    send(2, {8'h01, 8'h00, 24'h0});
    check(device_status_o[0], 1'b1);
    wait_ready(1100);
    check(device_status_o, 8'h00);
  endtask

  task automatic t_ctl();
    int s, a, v;
    s = susp_cnt;
    a = abort_cnt;
    v = vld_cnt;
    send(1, WRITE_ENABLE_CMD);
    send(5, {8'h02, 24'h010203, 8'hA5});
    check(vld_cnt, v + 1);
    check({prog_data_o, op_addr_o}, {8'hA5, 32'h00010203});
    send(1, {8'h75, 32'h0});
    check(susp_cnt, s + 1);
    check(device_status_o[0], 1'b1);
    send(1, {8'h66, 32'h0});
    send(1, {8'h99, 32'h0});
    check(abort_cnt, a + 1);
    check(device_status_o[1:0], 2'b00);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_latch();
    t_no_latch();
    t_engine();
    t_status();
    t_protect();
    t_lock();
    t_ctl();
    give_verdict();
  end
endmodule // fsw_status_we_tb

bind fsw_status_we fsw_status_we_properties chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .op_done_i(op_done_i),
  .device_status_o(device_status_o), .quad_pins_o(quad_pins_o),
  .wp_hold_pins_o(wp_hold_pins_o), .op_req_o(op_req_o),
  .op_code_o(op_code_o), .so_oe_o(so_oe_o));
